// >>> design/micint_ctrl.sv
// interrupt request, enable and edge-select registers with vector request
// assumes a byte register port from the core and pulse requests from peripherals
//
// How it works
// - edge field: off, rising, falling, both
// - high edge register upper nibble reads zero
// - wake interrupt needs global and uart enables
// - flags, enables, fields read/write, reset zero
// - first control: ext2..0 flags, enables, global
// - second control: uart, ext5..3 flags and enables
// - uart halts while its clock stops
// - uart registers untouched by power-down
// - armed rx pin falling edge wakes device
// - rx data discarded during start-up interval
// - wake interrupt raised after start-up only
// - accepts pin, timer, converter and peripheral sources
// - third control: adc and group flags, enables
// - fourth control: serial, eeprom, time bases
// - flags set regardless, group flags only for enabled members; vector needs both enables
// - vector entry clears global enable, flags still latch
`timescale 1ns/1ns
`default_nettype none
module micint_ctrl #(
  parameter int NUM_EXT = 6,
  parameter int START_CYCLES = micint_pkg::START_UP_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port from the core
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  // vector handshake with the core
  output logic int_req_r,
  output logic [3:0] int_vec_r,
  input wire logic vec_ack,
  // request sources
  input wire logic [NUM_EXT-1:0] ext_int_pin_n,
  input wire micint_pkg::mic_src_t src,
  // uart power-down and wake-up
  input wire logic pwr_down,
  input wire micint_pkg::mic_wake_cfg_t wake_cfg,
  input wire logic uart_rx_pin,
  output logic sys_wake_r,
  output logic uart_run_r,
  output logic uart_rx_discard_r
);

  ////////////////////////////////////////////////////////////////////////////
  // register store and access helpers

  logic [7:0] regs_r [micint_pkg::NUM_REGS];
  logic [7:0] set_v [micint_pkg::NUM_REGS];
  logic [7:0] clr_v [micint_pkg::NUM_REGS];
  logic [7:0] mask_v [micint_pkg::NUM_REGS];

  // hardware set wins over both a software write and a vector clear
  function automatic logic [7:0] reg_next(input logic [7:0] cur, input logic hit,
      input logic [7:0] wdata, input logic [7:0] setb, input logic [7:0] clrb,
      input logic [7:0] mask);
    logic [7:0] base;
    base = hit ? wdata : cur;
    reg_next = ((base & ~clrb) | setb) & mask;
  endfunction

  // lowest pending enabled source wins
  function automatic logic [3:0] pick(input logic [micint_pkg::NUM_VEC-1:0] req);
    pick = micint_pkg::VEC_NONE;
    for (int i = micint_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (req[i]) pick = 4'(i);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // external pins

  wire [7:0] edge_low = regs_r[micint_pkg::IDX_EDGE_LOW];
  wire [7:0] edge_high = regs_r[micint_pkg::IDX_EDGE_HIGH];
  wire [2*NUM_EXT-1:0] edge_sel = {edge_high[3:0], edge_low};
  logic [NUM_EXT-1:0] ext_evt;

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      micint_edge_det u_edge (
        .core_clk(core_clk),
        .reset(reset),
        .pin(ext_int_pin_n[g]),
        .sel(edge_sel[2*g+1:2*g]),
        .evt(ext_evt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // uart power-down and wake-up

  wire [7:0] ctrl_a = regs_r[micint_pkg::IDX_CTRL_A];
  wire [7:0] ctrl_b = regs_r[micint_pkg::IDX_CTRL_B];
  wire [7:0] ctrl_c = regs_r[micint_pkg::IDX_CTRL_C];
  wire [7:0] ctrl_d = regs_r[micint_pkg::IDX_CTRL_D];
  wire [7:0] mf_a = regs_r[micint_pkg::IDX_MF_A];
  wire [7:0] mf_b = regs_r[micint_pkg::IDX_MF_B];
  wire [7:0] mf_c = regs_r[micint_pkg::IDX_MF_C];
  wire glob_int_en = ctrl_a[micint_pkg::POS_GLOB_EN];
  wire uart_int_en = ctrl_b[micint_pkg::POS_UART_EN];
  logic wake_int;

  micint_uart_wake #(
    .START_CYCLES(START_CYCLES)
  ) u_wake (
    .core_clk(core_clk),
    .reset(reset),
    .pwr_down(pwr_down),
    .cfg(wake_cfg),
    .int_allowed(glob_int_en & uart_int_en),
    .rx_pin(uart_rx_pin),
    .wake_r(sys_wake_r),
    .uart_run_r(uart_run_r),
    .rx_discard_r(uart_rx_discard_r),
    .wake_int_r(wake_int)
  );

  ////////////////////////////////////////////////////////////////////////////
  // group registers: a group flag rises when an enabled member fires

  wire [7:0] mf_a_set = {2'h0, src.compact_a, src.compact_p, 4'h0};
  wire [7:0] mf_b_set = {src.low_volt, 1'b0, src.standard_a, src.standard_p, 4'h0};
  wire [7:0] mf_c_set = {src.periodic_a[1], src.periodic_p[1], src.periodic_a[0],
                         src.periodic_p[0], 4'h0};
  wire [2:0] mf_evt = {|(mf_c_set[7:4] & mf_c[3:0]),
                       |(mf_b_set[7:4] & mf_b[3:0]),
                       |(mf_a_set[7:4] & mf_a[3:0])};

  ////////////////////////////////////////////////////////////////////////////
  // pending and enabled sources in vector order

  wire [micint_pkg::NUM_VEC-1:0] pend = {ctrl_c[6:4], ctrl_d[7], ctrl_d[6], ctrl_c[7],
                                         ctrl_d[5], ctrl_d[4], ctrl_b[7], ctrl_b[6:4],
                                         ctrl_a[6:4]};
  wire [micint_pkg::NUM_VEC-1:0] enab = {ctrl_c[2:0], ctrl_d[3], ctrl_d[2], ctrl_c[3],
                                         ctrl_d[1], ctrl_d[0], ctrl_b[3], ctrl_b[2:0],
                                         ctrl_a[3:1]};
  wire [micint_pkg::NUM_VEC-1:0] live = pend & enab;
  wire [3:0] vec_sel = pick(live);
  // a vector is offered only with both enables set
  wire req_nxt = glob_int_en & (|live) & ~vec_ack;

  // taking the vector clears its primary flag
  wire [15:0] taken = vec_ack ? (16'h0001 << int_vec_r) : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // set, clear and implemented-bit vectors per register

  wire uart_set = src.uart | wake_int;
  always_comb begin
    set_v[micint_pkg::IDX_EDGE_LOW] = 8'h00;
    set_v[micint_pkg::IDX_EDGE_HIGH] = 8'h00;
    set_v[micint_pkg::IDX_CTRL_A] = {1'b0, ext_evt[2:0], 4'h0};
    set_v[micint_pkg::IDX_CTRL_B] = {uart_set, ext_evt[5:3], 4'h0};
    set_v[micint_pkg::IDX_CTRL_C] = {src.adc, mf_evt, 4'h0};
    set_v[micint_pkg::IDX_CTRL_D] = {src.serial_if, src.eeprom, src.time_base, 4'h0};
    set_v[micint_pkg::IDX_MF_A] = mf_a_set;
    set_v[micint_pkg::IDX_MF_B] = mf_b_set;
    set_v[micint_pkg::IDX_MF_C] = mf_c_set;
  end

  always_comb begin
    clr_v[micint_pkg::IDX_EDGE_LOW] = 8'h00;
    clr_v[micint_pkg::IDX_EDGE_HIGH] = 8'h00;
    clr_v[micint_pkg::IDX_CTRL_A] = {1'b0, taken[2:0], 3'h0, vec_ack};
    clr_v[micint_pkg::IDX_CTRL_B] = {taken[6], taken[5:3], 4'h0};
    clr_v[micint_pkg::IDX_CTRL_C] = {taken[9], taken[14:12], 4'h0};
    clr_v[micint_pkg::IDX_CTRL_D] = {taken[11], taken[10], taken[8], taken[7], 4'h0};
    clr_v[micint_pkg::IDX_MF_A] = 8'h00;
    clr_v[micint_pkg::IDX_MF_B] = 8'h00;
    clr_v[micint_pkg::IDX_MF_C] = 8'h00;
  end

  always_comb begin
    mask_v[micint_pkg::IDX_EDGE_LOW] = micint_pkg::MASK_FULL;
    mask_v[micint_pkg::IDX_EDGE_HIGH] = micint_pkg::MASK_EDGE_HIGH;
    mask_v[micint_pkg::IDX_CTRL_A] = micint_pkg::MASK_CTRL_A;
    mask_v[micint_pkg::IDX_CTRL_B] = micint_pkg::MASK_FULL;
    mask_v[micint_pkg::IDX_CTRL_C] = micint_pkg::MASK_FULL;
    mask_v[micint_pkg::IDX_CTRL_D] = micint_pkg::MASK_FULL;
    mask_v[micint_pkg::IDX_MF_A] = micint_pkg::MASK_MF_A;
    mask_v[micint_pkg::IDX_MF_B] = micint_pkg::MASK_MF_B;
    mask_v[micint_pkg::IDX_MF_C] = micint_pkg::MASK_FULL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: unmapped indices read zero

  wire rd_hit = (reg_addr < 4'(micint_pkg::NUM_REGS));
  wire [7:0] rd_mux = rd_hit ? regs_r[reg_addr] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // state

  generate
    for (g = 0; g < micint_pkg::NUM_REGS; g++) begin : g_reg
      wire hit = reg_wr && (reg_addr == 4'(g));
      always_ff @(posedge core_clk) begin
        if (reset) begin
          regs_r[g] <= micint_pkg::REG_RESET;
        end else begin
          regs_r[g] <= reg_next(regs_r[g], hit, reg_wdata, set_v[g], clr_v[g], mask_v[g]);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_r <= 8'h00;
      int_req_r <= 1'b0;
      int_vec_r <= micint_pkg::VEC_NONE;
    end else begin
      if (reg_rd) reg_rdata_r <= rd_mux;
      int_req_r <= req_nxt;
      int_vec_r <= vec_sel;
    end
  end
endmodule
`default_nettype wire

// >>> design/micint_edge_det.sv
// one external interrupt pin: synchroniser and edge selector
// assumes the pin is asynchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module micint_edge_det (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pin and selection
  input wire logic pin,
  input wire logic [1:0] sel,
  // detected edge, one cycle
  output logic evt
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  wire rise = sync_r & ~prev_r;
  wire fall = ~sync_r & prev_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_comb begin
    case (sel)
      micint_pkg::EDGE_OFF: evt = 1'b0;
      micint_pkg::EDGE_RISE: evt = rise;
      micint_pkg::EDGE_FALL: evt = fall;
      micint_pkg::EDGE_BOTH: evt = rise | fall;
      default: evt = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// >>> design/micint_uart_wake.sv
// uart power-down, receive-pin wake-up and start-up hold-off
// assumes rx pin is asynchronous; pwr_down is a core-clock level
`timescale 1ns/1ns
`default_nettype none
module micint_uart_wake #(
  parameter int START_CYCLES = micint_pkg::START_UP_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // power state and configuration
  input wire logic pwr_down,
  input wire micint_pkg::mic_wake_cfg_t cfg,
  input wire logic int_allowed,
  input wire logic rx_pin,
  // results
  output logic wake_r,
  output logic uart_run_r,
  output logic rx_discard_r,
  output logic wake_int_r
);
  micint_pkg::mic_pwr_state_t state_r, state_nxt;
  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;
  logic armed_r;
  logic [15:0] cnt_r;
  wire rx_fall = rx_prev_r & ~rx_sync_r;
  wire arm_now = cfg.rx_wake_en & cfg.uart_en_a & cfg.rx_en_b & cfg.rx_int_en;
  wire cnt_done = (cnt_r == 16'h0000);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      micint_pkg::MIC_RUN: if (pwr_down) state_nxt = micint_pkg::MIC_DOWN;
      micint_pkg::MIC_DOWN: begin
        if (armed_r && rx_fall) state_nxt = micint_pkg::MIC_START;
        else if (!pwr_down) state_nxt = micint_pkg::MIC_RUN;
      end
      micint_pkg::MIC_START: if (cnt_done) state_nxt = micint_pkg::MIC_RUN;
      default: state_nxt = micint_pkg::MIC_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= micint_pkg::MIC_RUN;
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
      armed_r <= 1'b0;
      cnt_r <= 16'h0000;
      wake_r <= 1'b0;
      uart_run_r <= 1'b1;
      rx_discard_r <= 1'b0;
      wake_int_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
      // arming is sampled as power-down is entered
      if (state_r == micint_pkg::MIC_RUN) armed_r <= arm_now;
      if (state_nxt == micint_pkg::MIC_START && state_r != micint_pkg::MIC_START) begin
        cnt_r <= 16'(START_CYCLES - 1);
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      wake_r <= (state_r == micint_pkg::MIC_DOWN) && (state_nxt == micint_pkg::MIC_START);
      // uart clock stops while down; its registers simply hold
      uart_run_r <= (state_nxt == micint_pkg::MIC_RUN);
      rx_discard_r <= (state_nxt == micint_pkg::MIC_START);
      wake_int_r <= (state_r == micint_pkg::MIC_START) && cnt_done && int_allowed;
    end
  end
endmodule
`default_nettype wire

// >>> shared/micint_pkg.sv
// constants, register indices and carriers of the interrupt controller
// assumes one core clock and a byte-wide data-memory register port
package micint_pkg;

  // register indices on the data-memory port
  localparam logic [3:0] IDX_EDGE_LOW = 4'h0;
  localparam logic [3:0] IDX_EDGE_HIGH = 4'h1;
  localparam logic [3:0] IDX_CTRL_A = 4'h2;
  localparam logic [3:0] IDX_CTRL_B = 4'h3;
  localparam logic [3:0] IDX_CTRL_C = 4'h4;
  localparam logic [3:0] IDX_CTRL_D = 4'h5;
  localparam logic [3:0] IDX_MF_A = 4'h6;
  localparam logic [3:0] IDX_MF_B = 4'h7;
  localparam logic [3:0] IDX_MF_C = 4'h8;
  localparam int NUM_REGS = 9;

  // reset value and implemented bits
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_EDGE_HIGH = 8'h0F;
  localparam logic [7:0] MASK_CTRL_A = 8'h7F;
  localparam logic [7:0] MASK_MF_A = 8'h33;
  localparam logic [7:0] MASK_MF_B = 8'hBB;

  // field positions
  localparam int POS_GLOB_EN = 0;
  localparam int POS_UART_EN = 3;
  localparam int POS_HI_FLAG = 7;

  // edge-select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // vector numbers, lowest wins
  localparam int NUM_VEC = 15;
  localparam logic [3:0] VEC_UART = 4'h6;
  localparam logic [3:0] VEC_NONE = 4'hF;

  // post-wake start-up interval
  localparam int CLK_PERIOD_NS = 50;
  localparam int START_UP_NS = 51200;
  localparam int START_UP_CYCLES = (START_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MIC_RUN = 2'h0,
    MIC_DOWN = 2'h1,
    MIC_START = 2'h3
  } mic_pwr_state_t;

  // one-cycle request pulses from on-chip peripherals
  typedef struct packed {
    logic adc;
    logic eeprom;
    logic serial_if;
    logic uart;
    logic [1:0] time_base;
    logic compact_a;
    logic compact_p;
    logic standard_a;
    logic standard_p;
    logic low_volt;
    logic [1:0] periodic_a;
    logic [1:0] periodic_p;
  } mic_src_t;

  // uart configuration levels that arm the receive-pin wake-up
  typedef struct packed {
    logic rx_wake_en;
    logic uart_en_a;
    logic rx_en_b;
    logic rx_int_en;
  } mic_wake_cfg_t;

endpackage

// >>> test/micint_core_model.sv
// core model: takes offered vectors after a set latency
// assumes int_req_r holds until acknowledged
`timescale 1ns/1ns
`default_nettype none
module micint_core_model (
  // clock, reset
  input wire logic core_clk,
  input wire logic reset,
  // test control
  input wire logic ack_on,
  input wire logic [3:0] ack_lat,
  // vector handshake
  input wire logic int_req_r,
  input wire logic [3:0] int_vec_r,
  output logic vec_ack,
  output logic [3:0] last_vec,
  output logic [7:0] ack_cnt
);
  logic [3:0] wait_r;
  // no second ack: the request only drops the cycle after an ack
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vec_ack <= 1'b0;
      last_vec <= 4'hF;
      ack_cnt <= 8'h00;
      wait_r <= 4'h0;
    end else begin
      vec_ack <= 1'b0;
      if (int_req_r && ack_on && !vec_ack) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= ack_lat) begin
          vec_ack <= 1'b1;
          last_vec <= int_vec_r;
          ack_cnt <= ack_cnt + 8'h01;
          wait_r <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/micint_ctrl_asserts.sv
// port checker for the interrupt controller
// assumes one core clock and a sync reset
`timescale 1ns/1ns
`default_nettype none
module micint_ctrl_asserts #(
  parameter int START_CYCLES = 8
) (
  // clock, reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  // vector
  input wire logic int_req_r,
  input wire logic [3:0] int_vec_r,
  input wire logic vec_ack,
  // power
  input wire logic pwr_down,
  input wire logic sys_wake_r,
  input wire logic uart_run_r,
  input wire logic uart_rx_discard_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // hold-off length, wide enough for the full start-up count
  logic [15:0] hold_r;
  always_ff @(posedge core_clk) begin
    if (reset || !uart_rx_discard_r) begin
      hold_r <= 16'h0000;
    end else begin
      hold_r <= hold_r + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ack_drops_req: assert property (vec_ack |=> !int_req_r)
    else $error("request held after ack");
  a_ack_clears_glob: assert property (vec_ack && !reg_wr ##1 reg_rd && reg_addr == 4'h2
    |=> !reg_rdata_r[0]) else $error("global enable kept after ack");
  a_req_has_vec: assert property (int_req_r |-> int_vec_r != 4'hF)
    else $error("request without vector");
  a_edge_high_zero: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata_r[7:4] == 4'h0)
    else $error("edge high upper bits set");
  a_ctrl_a_top: assert property (reg_rd && reg_addr == 4'h2 |=> !reg_rdata_r[7])
    else $error("control a bit 7 set");
  a_unmapped_rd: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  a_wake_start: assert property (sys_wake_r |-> $past(pwr_down) && uart_rx_discard_r
    && !uart_run_r ##1 !sys_wake_r) else $error("bad wake pulse");
  a_hold_len: assert property ($fell(uart_rx_discard_r) |-> hold_r == 16'(START_CYCLES))
    else $error("start-up length wrong");
  a_discard_halt: assert property (uart_rx_discard_r |-> !uart_run_r)
    else $error("uart runs in start-up");
  a_down_halts: assert property ($rose(pwr_down) |-> ##[1:2] !uart_run_r)
    else $error("uart runs in power-down");
endmodule

bind micint_ctrl micint_ctrl_asserts #(.START_CYCLES(START_CYCLES)) u_chk (.core_clk, .reset,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata_r, .int_req_r, .int_vec_r, .vec_ack, .pwr_down,
  .sys_wake_r, .uart_run_r, .uart_rx_discard_r);
`default_nettype wire

// >>> test/tb_micint_ctrl.sv
// self-checking bench for the interrupt controller
// assumes the core model file and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module tb_micint_ctrl;
  localparam int START = 8;
  localparam logic [7:0] IMPL [10] = '{8'hFF, 8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h33, 8'hBB,
    8'hFF, 8'h00};
  localparam int S_BIT [9] = '{14, 13, 12, 9, 10, 11, 8, 4, 3};
  localparam logic [3:0] S_REG [9] = '{4'h4, 4'h5, 4'h5, 4'h5, 4'h5, 4'h3, 4'h6, 4'h7, 4'h8};
  localparam logic [7:0] S_EN [9] = '{8'h08, 8'h04, 8'h08, 8'h01, 8'h02, 8'h08, 8'h02, 8'h08,
    8'h08};
  localparam logic [7:0] S_GRP [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02,
    8'h04};
  localparam logic [3:0] S_VEC [9] = '{4'h9, 4'hA, 4'hB, 4'h7, 4'h8, 4'h6, 4'hC, 4'hD, 4'hE};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [5:0] ext_int_pin_n = 6'h00;
  micint_pkg::mic_src_t src = '0;
  logic pwr_down = 1'b0;
  micint_pkg::mic_wake_cfg_t wake_cfg = '0;
  logic uart_rx_pin = 1'b1;
  logic ack_on = 1'b0;
  logic [3:0] ack_lat = 4'h0;
  logic [7:0] reg_rdata_r, ack_cnt;
  logic [3:0] int_vec_r, last_vec;
  logic int_req_r, vec_ack, sys_wake_r, uart_run_r, uart_rx_discard_r;
  int err_total = 0;
  int check_count = 0;

  micint_ctrl #(.NUM_EXT(6), .START_CYCLES(START)) u_dut (.core_clk, .reset, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .int_req_r, .int_vec_r, .vec_ack,
    .ext_int_pin_n, .src, .pwr_down, .wake_cfg, .uart_rx_pin, .sys_wake_r, .uart_run_r,
    .uart_rx_discard_r);
  micint_core_model u_core (.core_clk, .reset, .ack_on, .ack_lat, .int_req_r, .int_vec_r,
    .vec_ack, .last_vec, .ack_cnt);

  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes drop for a cycle so back-to-back calls never collide
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    chk(reg_rdata_r, exp);
  endtask
  task automatic finish_test();
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 10; i++) begin
      rdchk(4'(i), 8'h00);
      wr(4'(i), 8'hFF);
      rdchk(4'(i), IMPL[i]);
      wr(4'(i), 8'h00);
      rdchk(4'(i), 8'h00);
    end
    wr(4'h4, 8'h00);
  endtask
  task automatic t_sources();
    logic [7:0] c0;
    int n;
    ack_on = 1'b1;
    for (int i = 0; i < 9; i++) begin
      ack_lat = 4'(i % 3);
      wr(4'h4, S_GRP[i]);
      wr(S_REG[i], S_EN[i]);
      c0 = ack_cnt;
      src = micint_pkg::mic_src_t'(15'h0001 << S_BIT[i]);
      tick(1);
      src = '0;
      tick(4);
      chk({7'h00, int_req_r}, 8'h00);
      wr(4'h2, 8'h01);
      n = 0;
      while (ack_cnt === c0 && n < 20) begin
        tick(1);
        n++;
      end
      // read in the cycle after the ack, so the bound check sees the global enable drop
      tick(1);
      rdchk(4'h2, 8'h00);
      chk(ack_cnt, c0 + 8'h01);
      chk({4'h0, last_vec}, {4'h0, S_VEC[i]});
      wr(S_REG[i], 8'h00);
      wr(4'h4, 8'h00);
    end
    ack_on = 1'b0;
  endtask
  task automatic t_ext(input int pin, input logic [3:0] er, input int sh, input logic [3:0] fr,
                       input logic [7:0] fb);
    for (int c = 0; c < 4; c++) begin
      wr(er, 8'(c << sh));
      ext_int_pin_n[pin] = 1'b1;
      tick(5);
      rdchk(fr, (c == 1 || c == 3) ? fb : 8'h00);
      wr(fr, 8'h00);
      ext_int_pin_n[pin] = 1'b0;
      tick(5);
      rdchk(fr, (c == 2 || c == 3) ? fb : 8'h00);
      wr(fr, 8'h00);
    end
    wr(er, 8'h00);
  endtask
  task automatic t_wake(input logic [3:0] cfg, input logic [7:0] en_b, input logic [7:0] glob,
                        input logic woke, input logic [7:0] flag);
    int n;
    wake_cfg = micint_pkg::mic_wake_cfg_t'(cfg);
    wr(4'h3, en_b);
    wr(4'h2, glob);
    pwr_down = 1'b1;
    tick(3);
    chk({7'h00, uart_run_r}, 8'h00);
    uart_rx_pin = 1'b0;
    n = 0;
    while (sys_wake_r !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk({7'h00, sys_wake_r}, {7'h00, woke});
    if (woke) begin
      // line activity during start-up must be dropped
      uart_rx_pin = 1'b1;
      tick(1);
      uart_rx_pin = 1'b0;
      tick(1);
      uart_rx_pin = 1'b1;
      n = 0;
      while (uart_rx_discard_r === 1'b1 && n < 50) begin
        tick(1);
        n++;
      end
      chk(8'(n + 2), 8'(START));
      chk({6'h00, int_req_r, uart_run_r}, 8'h01);
    end
    pwr_down = 1'b0;
    uart_rx_pin = 1'b1;
    tick(3);
    rdchk(4'h3, flag);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    reset = 1'b0;
    tick(2);
    t_regs();
    t_sources();
    t_ext(0, 4'h0, 0, 4'h2, 8'h10);
    t_ext(3, 4'h0, 6, 4'h3, 8'h10);
    t_ext(5, 4'h1, 2, 4'h3, 8'h40);
    t_wake(4'h7, 8'h08, 8'h01, 1'b0, 8'h08);
    t_wake(4'hF, 8'h00, 8'h00, 1'b1, 8'h00);
    t_wake(4'hF, 8'h08, 8'h00, 1'b1, 8'h08);
    t_wake(4'hF, 8'h08, 8'h01, 1'b1, 8'h88);
    finish_test();
  end
  initial begin
    #(50 * 20000);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
